// File: isc_cfg.svh
`ifndef ISC_CFG_SVH
`define ISC_CFG_SVH

// clock and time base
`define ISC_CLK_PERIOD_NS   25
`define ISC_SECOND_NS       1000000000

// queue and buffer sizes
`define ISC_CMD_QUEUE_LIMIT 4
`define ISC_ERR_DEPTH       10

// standard event register bit positions
`define ISC_ESR_OPC         0
`define ISC_ESR_QYE         2
`define ISC_ESR_DDE         3
`define ISC_ESR_EXE         4
`define ISC_ESR_CME         5
`define ISC_ESR_PON         7
`define ISC_ESR_USED_MASK   8'hBD

// status byte bit positions
`define ISC_STB_QUENCH      2
`define ISC_STB_ERRQ        3
`define ISC_STB_MAV         4
`define ISC_STB_ESB         5
`define ISC_STB_RQS         6

// reset values
`define ISC_PSC_RESET       1'b1
`define ISC_MASK_RESET      8'h00
`define ISC_ESR_RESET       8'h80
`define ISC_MONTH_RESET     4'h1
`define ISC_DAY_RESET       5'h01
`define ISC_YEAR_RESET      12'h7D0

// error codes, 16-bit two's complement
`define ISC_ERR_NONE        16'h0000
`define ISC_ERR_COMMAND     16'hFF9C
`define ISC_ERR_SETTINGS    16'hFF23
`define ISC_ERR_OVERFLOW    16'hFED1

// date/time word layout: month day year hour minute second
`define ISC_TM_MONTH_LSB    34
`define ISC_TM_DAY_LSB      29
`define ISC_TM_YEAR_LSB     17
`define ISC_TM_HOUR_LSB     12
`define ISC_TM_MIN_LSB      6
`define ISC_TM_SEC_LSB      0

`endif

// File: isc_core.sv
`timescale 1ns/10ps
`include "isc_cfg.svh"

module isc_fifo #(
    parameter int W     = 46,
    parameter int DEPTH = 8
) (
    input  wire logic                       clk,
    input  wire logic                       rst_b,
    input  wire logic                       flush,
    input  wire logic                       in_valid,
    output logic                            in_ready,
    input  wire logic [W-1:0]               in_data,
    output logic                            out_valid,
    input  wire logic                       out_ready,
    output logic [W-1:0]                    out_data,
    output logic [$clog2(DEPTH+1)-1:0]      count
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           rd;
        logic [AW-1:0]           wr;
        logic [CW-1:0]           cnt;
    } isc_fifo_st_t;

    isc_fifo_st_t st_ff;
    isc_fifo_st_t nxt_st;
    logic         push;
    logic         pop;

    assign in_ready  = (st_ff.cnt != CW'(DEPTH));
    assign out_valid = (st_ff.cnt != '0);
    assign out_data  = st_ff.mem[st_ff.rd];
    assign count     = st_ff.cnt;
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    function automatic logic [AW-1:0] inc_ptr(input logic [AW-1:0] p);
        inc_ptr = (p == AW'(DEPTH-1)) ? '0 : AW'(p + 1'b1);
    endfunction

    always_comb begin
        nxt_st = st_ff;
        if (push) begin
            nxt_st.mem[st_ff.wr] = in_data;
            nxt_st.wr            = inc_ptr(st_ff.wr);
        end
        if (pop) begin
            nxt_st.rd = inc_ptr(st_ff.rd);
        end
        nxt_st.cnt = CW'(st_ff.cnt + CW'(push) - CW'(pop));
        if (flush) begin
            nxt_st.rd  = '0;
            nxt_st.wr  = '0;
            nxt_st.cnt = '0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule // isc_fifo

// Function
// - identify query answers model number and firmware revision.
// - reset command behaves like power cycle; enable masks cleared per power-on clear. Code keeps time, date and power-on clear at the reset command.
// - self-test query always answers 1.
// - ctrl-C empties output and command buffers, status untouched.
// - panel controls enabled after reset; local command re-enables them.
// - remote command locks panel, shows marker; local, reset, shift-menu unlock.
// - date/time reported as month/day/year and 24-hour hours:minutes:seconds.
// - up to 10 pending errors, returned oldest first.
// - errors removed when read; buffer emptied by clear-status or power cycle.
// - status byte query does not clear summary bit 6.
// - service request mask selects status bits feeding bit 6; 4 selects quench.
// - each mask query returns the last mask written.
// - clear-status clears event register and error buffer.
// - event status query returns event register contents.
// - event enable mask selects event bits summarised into status bit 5.
// - power-on clear 1 clears masks at power on, 0 keeps; default 1; queryable. Code applies it at the reset command only; power on always clears masks.
// - operation-complete command sets event bit 0.
// - operation-complete query answers 1 only to its sender.
// - supply type query returns index 0..17, panel-only setting.
// - supply limits and output range are read-only remotely.
// - output range codes 0..5 as fixed voltage ranges.
// - field-unit commands refused unless field-to-current ratio is positive.
// - current ceiling bounds operating current magnitude symmetrically.
// - event bits: 0 opc, 2 query, 3 device, 4 exec, 5 command, 7 power-on.
// - reading the event register clears it.
// - queue 4 commands; overflow discards and logs error -303.
module isc_core
    import isc_pkg::*;
#(
    parameter int          TICKS_PER_SEC = `ISC_SECOND_NS / `ISC_CLK_PERIOD_NS,
    parameter int          FIFO_DEPTH    = 8,
    parameter logic [23:0] ID_MODEL      = 24'h000001, // arbitrary value
    parameter logic [15:0] ID_FW_REV     = 16'h0001    // arbitrary value
) (
    input  wire logic               CLOCK,
    input  wire logic               RST_B,
    input  wire logic               CMD_VALID,
    output logic                    CMD_READY,
    input  wire logic [4:0]         CMD_OP,
    input  wire logic [39:0]        CMD_ARG,
    input  wire logic               CMD_SRC,
    input  wire logic               ABORT,
    output logic                    RESP_VALID,
    input  wire logic               RESP_READY,
    output logic [39:0]             RESP_DATA,
    output logic                    RESP_DST,
    input  wire logic               PANEL_SHIFT_MENU,
    input  wire logic               QUENCH,
    input  wire logic               DEVICE_FAULT,
    input  wire logic [4:0]         SUPPLY_TYPE,
    input  wire logic [15:0]        SUPPLY_VMIN,
    input  wire logic [15:0]        SUPPLY_VMAX,
    input  wire logic [15:0]        SUPPLY_IMIN,
    input  wire logic [15:0]        SUPPLY_IMAX,
    input  wire logic [2:0]         SUPPLY_RANGE,
    input  wire logic signed [31:0] FIELD_TO_CURRENT_RATIO,
    input  wire logic [15:0]        CURRENT_LIMIT,
    input  wire logic signed [15:0] CURRENT_REQ,
    output logic signed [15:0]      CURRENT_OUT,
    output logic                    FIELD_CMD_VALID,
    output logic [39:0]             FIELD_CMD_ARG,
    output logic                    PANEL_ENABLE,
    output logic                    REMOTE_MARK,
    output logic [7:0]              STATUS_BYTE
);
    localparam int TW = $clog2(TICKS_PER_SEC);
    localparam int CW = $clog2(FIFO_DEPTH+1);

    typedef struct packed {
        logic                                resp_valid;
        logic [39:0]                         resp_data;
        logic                                resp_dst;
        logic [7:0]                          esr;
        logic [7:0]                          ese;
        logic [7:0]                          sre;
        logic                                psc;
        logic                                remote;
        logic [`ISC_ERR_DEPTH-1:0][15:0]     err_mem;
        logic [3:0]                          err_cnt;
        logic [TW-1:0]                       tick;
        logic [3:0]                          month;
        logic [4:0]                          day;
        logic [11:0]                         year;
        logic [4:0]                          hour;
        logic [5:0]                          minute;
        logic [5:0]                          second;
        logic [7:0]                          stb;
        logic signed [15:0]                  cur;
        logic                                fcmd_valid;
        logic [39:0]                         fcmd_arg;
    } isc_core_st_t;

    isc_core_st_t  st_ff;
    isc_core_st_t  nxt_st;
    logic          q_valid;
    logic          q_pop;
    logic [45:0]   q_data;
    logic [CW-1:0] q_count;
    logic          q_room;
    isc_op_t       op;
    logic [39:0]   arg;
    logic          src;

    assign q_room    = (q_count < CW'(`ISC_CMD_QUEUE_LIMIT));
    assign CMD_READY = q_room;
    assign op        = isc_op_t'(q_data[45:41]);
    assign arg       = q_data[40:1];
    assign src       = q_data[0];
    assign q_pop     = q_valid & ~st_ff.resp_valid & ~ABORT;

    isc_fifo #(
        .W     (46),
        .DEPTH (FIFO_DEPTH)
    ) u_cmd_fifo (
        .clk       (CLOCK),
        .rst_b     (RST_B),
        .flush     (ABORT),
        .in_valid  (CMD_VALID & q_room),
        .in_ready  (),
        .in_data   ({CMD_OP, CMD_ARG, CMD_SRC}),
        .out_valid (q_valid),
        .out_ready (q_pop),
        .out_data  (q_data),
        .count     (q_count)
    );

    function automatic isc_core_st_t push_err(input isc_core_st_t s, input logic [15:0] code);
        isc_core_st_t r;
        r = s;
        if (s.err_cnt < 4'(`ISC_ERR_DEPTH)) begin
            r.err_mem[s.err_cnt] = code;
            r.err_cnt            = 4'(s.err_cnt + 1'b1);
        end
        return r;
    endfunction

    function automatic logic [4:0] month_days(input logic [3:0] m, input logic [11:0] y);
        if (m == 4'h2) begin
            month_days = (y[1:0] == 2'h0) ? 5'h1D : 5'h1C;
        end else if (m == 4'h4 || m == 4'h6 || m == 4'h9 || m == 4'hB) begin
            month_days = 5'h1E;
        end else begin
            month_days = 5'h1F;
        end
    endfunction

    function automatic logic [39:0] resp_num(input logic [15:0] v);
        resp_num = {24'h000000, v};
    endfunction

    always_comb begin
        nxt_st            = st_ff;
        nxt_st.fcmd_valid = 1'b0;
        // time base, hours kept in 24-hour form
        if (st_ff.tick == TW'(TICKS_PER_SEC - 1)) begin
            nxt_st.tick   = '0;
            nxt_st.second = 6'(st_ff.second + 1'b1);
            if (st_ff.second == 6'h3B) begin
                nxt_st.second = '0;
                nxt_st.minute = 6'(st_ff.minute + 1'b1);
                if (st_ff.minute == 6'h3B) begin
                    nxt_st.minute = '0;
                    nxt_st.hour   = 5'(st_ff.hour + 1'b1);
                    if (st_ff.hour == 5'h17) begin
                        nxt_st.hour = '0;
                        nxt_st.day  = 5'(st_ff.day + 1'b1);
                        if (st_ff.day == month_days(st_ff.month, st_ff.year)) begin
                            nxt_st.day   = 5'h01;
                            nxt_st.month = 4'(st_ff.month + 1'b1);
                            if (st_ff.month == 4'hC) begin
                                nxt_st.month = 4'h1;
                                nxt_st.year  = 12'(st_ff.year + 1'b1);
                            end
                        end
                    end
                end
            end
        end else begin
            nxt_st.tick = TW'(st_ff.tick + 1'b1);
        end
        if (RESP_READY && st_ff.resp_valid) begin
            nxt_st.resp_valid = 1'b0;
        end
        if (PANEL_SHIFT_MENU) begin
            nxt_st.remote = 1'b0;
        end
        if (q_pop) begin
            nxt_st.resp_dst = src;
            nxt_st.resp_valid = 1'b1;
            nxt_st.resp_data  = '0;
            case (op)
                OP_IDN_Q:      nxt_st.resp_data = {ID_MODEL, ID_FW_REV};
                OP_TST_Q:      nxt_st.resp_data = 40'h0000000001;
                OP_TIME_Q: begin
                    nxt_st.resp_data = {2'h0, st_ff.month, st_ff.day, st_ff.year,
                                        st_ff.hour, st_ff.minute, st_ff.second};
                end
                OP_ERR_Q: begin
                    nxt_st.resp_data = resp_num(st_ff.err_cnt != '0 ? st_ff.err_mem[0] : `ISC_ERR_NONE);
                    if (st_ff.err_cnt != '0) begin
                        for (int i = 0; i < `ISC_ERR_DEPTH - 1; i++) begin
                            nxt_st.err_mem[i] = st_ff.err_mem[i+1];
                        end
                        nxt_st.err_cnt = 4'(st_ff.err_cnt - 1'b1);
                    end
                end
                OP_STB_Q:      nxt_st.resp_data = resp_num({8'h00, st_ff.stb});
                OP_SRE_Q:      nxt_st.resp_data = resp_num({8'h00, st_ff.sre});
                OP_ESE_Q:      nxt_st.resp_data = resp_num({8'h00, st_ff.ese});
                OP_ESR_Q: begin
                    nxt_st.resp_data = resp_num({8'h00, st_ff.esr});
                    nxt_st.esr       = '0;
                end
                OP_PSC_Q:      nxt_st.resp_data = resp_num({15'h0000, st_ff.psc});
                OP_OPC_Q:      nxt_st.resp_data = 40'h0000000001;
                OP_SUP_TYPE_Q: nxt_st.resp_data = resp_num({11'h000, SUPPLY_TYPE});
                OP_SUP_VMIN_Q: nxt_st.resp_data = resp_num(SUPPLY_VMIN);
                OP_SUP_VMAX_Q: nxt_st.resp_data = resp_num(SUPPLY_VMAX);
                OP_SUP_IMIN_Q: nxt_st.resp_data = resp_num(SUPPLY_IMIN);
                OP_SUP_IMAX_Q: nxt_st.resp_data = resp_num(SUPPLY_IMAX);
                OP_SUP_MODE_Q: nxt_st.resp_data = resp_num({13'h0000, SUPPLY_RANGE});
                OP_RATIO_Q:    nxt_st.resp_data = {8'h00, FIELD_TO_CURRENT_RATIO};
                default: begin
                    // commands give no answer
                    nxt_st.resp_valid = 1'b0;
                    case (op)
                        OP_RST: begin
                            // clears remote, errors and event register like power cycle; masks per power-on clear, time and date kept, calibration lives outside
                            nxt_st.remote  = 1'b0;
                            nxt_st.err_cnt = '0;
                            nxt_st.esr     = `ISC_ESR_RESET;
                            if (st_ff.psc) begin
                                nxt_st.ese = `ISC_MASK_RESET;
                                nxt_st.sre = `ISC_MASK_RESET;
                            end
                        end
                        OP_LOCAL:    nxt_st.remote = 1'b0;
                        OP_REMOTE:   nxt_st.remote = 1'b1;
                        OP_TIME_SET: begin
                            // host supplies fields in the same layout, 24-hour hours
                            nxt_st.month  = arg[`ISC_TM_MONTH_LSB +: 4];
                            nxt_st.day    = arg[`ISC_TM_DAY_LSB +: 5];
                            nxt_st.year   = arg[`ISC_TM_YEAR_LSB +: 12];
                            nxt_st.hour   = arg[`ISC_TM_HOUR_LSB +: 5];
                            nxt_st.minute = arg[`ISC_TM_MIN_LSB +: 6];
                            nxt_st.second = arg[`ISC_TM_SEC_LSB +: 6];
                            nxt_st.tick   = '0;
                        end
                        OP_SRE_SET:  nxt_st.sre = arg[7:0];
                        OP_ESE_SET:  nxt_st.ese = arg[7:0];
                        OP_PSC_SET:  nxt_st.psc = arg[0];
                        OP_CLS: begin
                            nxt_st.esr     = '0;
                            nxt_st.err_cnt = '0;
                        end
                        OP_OPC:      nxt_st.esr[`ISC_ESR_OPC] = 1'b1;
                        OP_FIELD_CMD: begin
                            if (FIELD_TO_CURRENT_RATIO > 32'sh0) begin
                                nxt_st.fcmd_valid = 1'b1;
                                nxt_st.fcmd_arg   = arg;
                            end else begin
                                nxt_st.esr[`ISC_ESR_EXE] = 1'b1;
                                nxt_st = push_err(nxt_st, `ISC_ERR_SETTINGS);
                            end
                        end
                        default: begin
                            nxt_st.esr[`ISC_ESR_CME] = 1'b1;
                            nxt_st = push_err(nxt_st, `ISC_ERR_COMMAND);
                        end
                    endcase
                end
            endcase
        end
        // events after clears, so an event in a clearing cycle survives
        if (CMD_VALID && !q_room) begin
            nxt_st.esr[`ISC_ESR_EXE] = 1'b1;
            nxt_st = push_err(nxt_st, `ISC_ERR_OVERFLOW);
        end
        if (DEVICE_FAULT) begin
            nxt_st.esr[`ISC_ESR_DDE] = 1'b1;
        end
        if (ABORT) begin
            nxt_st.resp_valid = 1'b0;
        end
        nxt_st.esr = nxt_st.esr & `ISC_ESR_USED_MASK;
        // ceiling bounds both polarities alike
        if (CURRENT_REQ > $signed({1'b0, CURRENT_LIMIT[14:0]})) begin
            nxt_st.cur = $signed({1'b0, CURRENT_LIMIT[14:0]});
        end else if (CURRENT_REQ < -$signed({1'b0, CURRENT_LIMIT[14:0]})) begin
            nxt_st.cur = -$signed({1'b0, CURRENT_LIMIT[14:0]});
        end else begin
            nxt_st.cur = CURRENT_REQ;
        end
        nxt_st.stb                 = '0;
        nxt_st.stb[`ISC_STB_QUENCH] = QUENCH;
        nxt_st.stb[`ISC_STB_ERRQ]  = (nxt_st.err_cnt != '0);
        nxt_st.stb[`ISC_STB_MAV]   = nxt_st.resp_valid;
        nxt_st.stb[`ISC_STB_ESB]   = |(nxt_st.esr & nxt_st.ese);
        nxt_st.stb[`ISC_STB_RQS]   = |(nxt_st.stb & nxt_st.sre & 8'hBF);
    end

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            st_ff        <= '0;
            st_ff.psc    <= `ISC_PSC_RESET;
            st_ff.esr    <= `ISC_ESR_RESET;
            st_ff.month  <= `ISC_MONTH_RESET;
            st_ff.day    <= `ISC_DAY_RESET;
            st_ff.year   <= `ISC_YEAR_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign RESP_VALID      = st_ff.resp_valid;
    assign RESP_DATA       = st_ff.resp_data;
    assign RESP_DST        = st_ff.resp_dst;
    assign CURRENT_OUT     = st_ff.cur;
    assign FIELD_CMD_VALID = st_ff.fcmd_valid;
    assign FIELD_CMD_ARG   = st_ff.fcmd_arg;
    assign PANEL_ENABLE    = ~st_ff.remote;
    assign REMOTE_MARK     = st_ff.remote;
    assign STATUS_BYTE     = st_ff.stb;
endmodule // isc_core

// File: isc_core_properties.sv
`timescale 1ns/10ps
module isc_core_properties (
    input wire logic               CLOCK,
    input wire logic               RST_B,
    input wire logic               CMD_VALID,
    input wire logic               CMD_READY,
    input wire logic               ABORT,
    input wire logic               RESP_VALID,
    input wire logic               RESP_READY,
    input wire logic [39:0]        RESP_DATA,
    input wire logic               RESP_DST,
    input wire logic               PANEL_SHIFT_MENU,
    input wire logic               QUENCH,
    input wire logic signed [31:0] FIELD_TO_CURRENT_RATIO,
    input wire logic [15:0]        CURRENT_LIMIT,
    input wire logic signed [15:0] CURRENT_REQ,
    input wire logic signed [15:0] CURRENT_OUT,
    input wire logic               FIELD_CMD_VALID,
    input wire logic               PANEL_ENABLE,
    input wire logic               REMOTE_MARK,
    input wire logic [7:0]         STATUS_BYTE
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RST_B);
    // only 15 limit bits so the negated bound always fits
    function automatic logic signed [15:0] clamp(logic signed [15:0] r, logic [15:0] l);
        logic signed [15:0] m;
        m = signed'({1'b0, l[14:0]});
        return (r > m) ? m : ((r < -m) ? -m : r);
    endfunction
    chk_current_clamp: assert property (CURRENT_OUT == clamp($past(CURRENT_REQ), $past(CURRENT_LIMIT)))
        else $error("current clamp wrong");
    chk_panel_mark: assert property (PANEL_ENABLE != REMOTE_MARK) else $error("marker mismatch");
    chk_panel_unlock: assert property (PANEL_SHIFT_MENU |=> PANEL_ENABLE) else $error("panel locked");
    chk_quench_bit: assert property (STATUS_BYTE[2] == $past(QUENCH)) else $error("quench bit");
    chk_resp_stands: assert property (RESP_VALID && !RESP_READY && !ABORT |=>
        RESP_VALID && $stable(RESP_DATA) && $stable(RESP_DST)) else $error("response moved");
    chk_resp_drop: assert property (RESP_VALID && RESP_READY |=> !RESP_VALID) else $error("response kept");
    chk_abort_flush: assert property (ABORT |=> !RESP_VALID && CMD_READY) else $error("abort left work");
    chk_field_gate: assert property (FIELD_CMD_VALID |-> $past(FIELD_TO_CURRENT_RATIO) > 0) else $error("field");
    chk_overflow_err: assert property (CMD_VALID && !CMD_READY |-> ##[1:3] STATUS_BYTE[3])
        else $error("overflow not logged");
    cover property (RESP_VALID && RESP_READY);
    cover property (ABORT ##1 CMD_READY);
    cover property (CMD_VALID && !CMD_READY);
endmodule // isc_core_properties

bind isc_core isc_core_properties isc_core_properties_inst (.*);

// File: isc_host.sv
`timescale 1ns/10ps
module isc_host (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic [3:0]  stall,
    input  wire logic        resp_valid,
    output logic             resp_ready,
    input  wire logic [39:0] resp_data,
    input  wire logic        resp_dst,
    output logic [40:0]      rx_word,
    output logic             rx_got
);
    logic [3:0] wait_ff;
    // slow host: ready only after stall cycles of offered data
    assign resp_ready = resp_valid && (wait_ff >= stall);
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wait_ff <= 4'h0;
            rx_got  <= 1'b0;
            rx_word <= 41'h0;
        end else begin
            wait_ff <= (resp_valid && !resp_ready) ? wait_ff + 4'h1 : 4'h0;
            rx_got  <= resp_ready;
            if (resp_ready) rx_word <= {resp_dst, resp_data};
        end
    end
endmodule // isc_host

// File: isc_pkg.sv
package isc_pkg;
    typedef enum logic [4:0] {
        OP_IDN_Q      = 5'h00,
        OP_RST        = 5'h01,
        OP_TST_Q      = 5'h02,
        OP_LOCAL      = 5'h03,
        OP_REMOTE     = 5'h04,
        OP_TIME_Q     = 5'h05,
        OP_TIME_SET   = 5'h06,
        OP_ERR_Q      = 5'h07,
        OP_STB_Q      = 5'h08,
        OP_SRE_SET    = 5'h09,
        OP_SRE_Q      = 5'h0A,
        OP_CLS        = 5'h0B,
        OP_ESR_Q      = 5'h0C,
        OP_ESE_SET    = 5'h0D,
        OP_ESE_Q      = 5'h0E,
        OP_PSC_SET    = 5'h0F,
        OP_PSC_Q      = 5'h10,
        OP_OPC        = 5'h11,
        OP_OPC_Q      = 5'h12,
        OP_SUP_TYPE_Q = 5'h13,
        OP_SUP_VMIN_Q = 5'h14,
        OP_SUP_VMAX_Q = 5'h15,
        OP_SUP_IMIN_Q = 5'h16,
        OP_SUP_IMAX_Q = 5'h17,
        OP_SUP_MODE_Q = 5'h18,
        OP_RATIO_Q    = 5'h19,
        OP_FIELD_CMD  = 5'h1A
    } isc_op_t;

    typedef enum logic [2:0] {
        RANGE_P5   = 3'h0,
        RANGE_P10  = 3'h1,
        RANGE_PM5  = 3'h2,
        RANGE_PM10 = 3'h3,
        RANGE_N5   = 3'h4,
        RANGE_P8   = 3'h5
    } isc_range_t;
endpackage

// File: testbench.sv
`timescale 1ns/10ps
module testbench;
    import isc_pkg::*;
    localparam logic [23:0] MODEL = 24'h00A5C3; // arbitrary value
    localparam logic [15:0] FW    = 16'h0007;   // arbitrary value
    localparam logic [95:0] SUP   = 96'h000C_0101_0202_0303_0404_0005;
    localparam logic [39:0] T0    = {2'h0, 4'hC, 5'h1F, 12'h7E9, 5'h17, 6'h3B, 6'h3B};
    localparam logic [39:0] T1    = {2'h0, 4'h1, 5'h01, 12'h7EA, 17'h0};
    logic               CLOCK, RST_B, CMD_VALID, CMD_READY, CMD_SRC, ABORT, RESP_VALID, RESP_READY, RESP_DST;
    logic               PANEL_SHIFT_MENU, QUENCH, DEVICE_FAULT, FIELD_CMD_VALID, PANEL_ENABLE, REMOTE_MARK, rx_got;
    logic [4:0]         CMD_OP, SUPPLY_TYPE;
    logic [39:0]        CMD_ARG, RESP_DATA, FIELD_CMD_ARG;
    logic [15:0]        SUPPLY_VMIN, SUPPLY_VMAX, SUPPLY_IMIN, SUPPLY_IMAX, CURRENT_LIMIT;
    logic [2:0]         SUPPLY_RANGE;
    logic signed [31:0] FIELD_TO_CURRENT_RATIO;
    logic signed [15:0] CURRENT_REQ, CURRENT_OUT;
    logic [7:0]         STATUS_BYTE;
    logic [40:0]        rx_word;
    logic [3:0]         stall;
    int                 err_count, checks;

    isc_core #(.TICKS_PER_SEC(40), .ID_MODEL(MODEL), .ID_FW_REV(FW)) isc_core_inst (.*);
    isc_host isc_host_inst (.clk(CLOCK), .rst_b(RST_B), .stall(stall), .resp_valid(RESP_VALID),
        .resp_ready(RESP_READY), .resp_data(RESP_DATA), .resp_dst(RESP_DST), .rx_word(rx_word), .rx_got(rx_got));

    initial begin
        CLOCK = 1'b0;
        forever #12.5 CLOCK = ~CLOCK;
    end

    task automatic give_verdict();
        if (err_count == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [40:0] got, input logic [40:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // waits at falling edges so combinational flags are settled
    task automatic wait_hi(input bit resp);
        int n = 0;
        @(negedge CLOCK);
        while ((resp ? rx_got : CMD_READY) !== 1'b1) begin
            if (++n > 60) begin
                err_count++;
                give_verdict();
            end
            @(negedge CLOCK);
        end
        @(posedge CLOCK);
    endtask
    task automatic send(input logic [4:0] op, input logic [39:0] arg, input logic src = 1'b0);
        CMD_OP <= op;
        CMD_ARG <= arg;
        CMD_SRC <= src;
        CMD_VALID <= 1'b1;
        wait_hi(1'b0);
        CMD_VALID <= 1'b0;
        @(posedge CLOCK);
    endtask
    task automatic query(input logic [4:0] op, input logic [39:0] exp, input logic src = 1'b0);
        send(op, 40'h0, src);
        wait_hi(1'b1);
        chk(rx_word, {src, exp});
    endtask

    initial begin
        {RST_B, CMD_VALID, CMD_SRC, ABORT, PANEL_SHIFT_MENU, QUENCH, DEVICE_FAULT, stall} = 11'h000;
        {CMD_OP, CMD_ARG, FIELD_TO_CURRENT_RATIO, CURRENT_REQ} = 93'h0;
        {SUPPLY_TYPE, SUPPLY_RANGE} = {5'h0C, RANGE_P8};
        {SUPPLY_VMIN, SUPPLY_VMAX, SUPPLY_IMIN, SUPPLY_IMAX, CURRENT_LIMIT} = 80'h0101_0202_0303_0404_0064;
        err_count = 0;
        checks = 0;
        repeat (8) @(posedge CLOCK);
        RST_B <= 1'b1;
        @(posedge CLOCK);
        chk(PANEL_ENABLE, 1);
        query(OP_PSC_Q, 1);
        query(OP_ESR_Q, 40'h80);
        query(OP_ESR_Q, 0);
        query(OP_IDN_Q, {MODEL, FW});
        query(OP_TST_Q, 1);
        query(OP_OPC_Q, 1, 1'b1);
        for (int i = 0; i < 6; i++) query(5'(5'h13 + i), 40'(SUP[80-16*i +: 16]));
        send(OP_SRE_SET, 4);
        send(OP_ESE_SET, 60);
        query(OP_SRE_Q, 4);
        query(OP_ESE_Q, 60);
        QUENCH <= 1'b1;
        send(OP_OPC, 0);
        repeat (3) @(posedge CLOCK);
        chk(STATUS_BYTE & 8'h64, 8'h44);
        repeat (2) query(OP_STB_Q, 40'h44);
        QUENCH <= 1'b0;
        query(OP_ESR_Q, 1);
        send(5'h1F, 0);
        repeat (3) @(posedge CLOCK);
        chk(STATUS_BYTE[5], 1);
        send(OP_FIELD_CMD, 40'h5);
        repeat (11) send(5'h1F, 0);
        query(OP_ERR_Q, 16'hFF9C);
        query(OP_ERR_Q, 16'hFF23);
        repeat (8) query(OP_ERR_Q, 16'hFF9C);
        query(OP_ERR_Q, 0);
        FIELD_TO_CURRENT_RATIO <= 32'h10;
        DEVICE_FAULT <= 1'b1;
        send(OP_FIELD_CMD, 40'h5);
        DEVICE_FAULT <= 1'b0;
        query(OP_ERR_Q, 0);
        chk(FIELD_CMD_ARG, 40'h5);
        query(OP_ESR_Q, 40'h38);
        send(5'h1F, 0);
        send(OP_CLS, 0);
        query(OP_ERR_Q, 0);
        query(OP_ESR_Q, 0);
        stall <= 4'hF;
        repeat (5) send(OP_TST_Q, 0);
        chk(CMD_READY, 0);
        CMD_VALID <= 1'b1;
        @(posedge CLOCK);
        CMD_VALID <= 1'b0;
        ABORT <= 1'b1;
        @(posedge CLOCK);
        ABORT <= 1'b0;
        stall <= 4'h0;
        @(negedge CLOCK);
        chk({RESP_VALID, CMD_READY}, 1);
        @(posedge CLOCK);
        query(OP_ERR_Q, 16'hFED1);
        query(OP_ESR_Q, 40'h10);
        send(OP_REMOTE, 0);
        repeat (3) @(posedge CLOCK);
        chk(PANEL_ENABLE, 0);
        PANEL_SHIFT_MENU <= 1'b1;
        @(posedge CLOCK);
        PANEL_SHIFT_MENU <= 1'b0;
        send(OP_PSC_SET, 0);
        send(OP_REMOTE, 0);
        send(OP_RST, 0);
        query(OP_SRE_Q, 4);
        query(OP_ESR_Q, 40'h80);
        chk(PANEL_ENABLE, 1);
        send(OP_TIME_SET, T0);
        query(OP_TIME_Q, T0);
        repeat (40) @(posedge CLOCK);
        query(OP_TIME_Q, T1);
        CURRENT_REQ <= 16'hFED4;
        repeat (2) @(posedge CLOCK);
        chk({CURRENT_OUT}, 16'hFF9C);
        give_verdict();
    end
endmodule // testbench
